/* include/amcc_pkg.sv */
/*
  Constants for the four-channel converter conversion control.
  Assumes a single system clock; MOD_DIVIDE counts its cycles, OVERSAMPLE modulator ticks, SETTLE_CYCLES results.
*/
// Summary of operation
// - Conversion timing derived from the system clock
// - Filter result loads the output data register
// - New result drives ready pin low
// - 8MHz clock gives 20.8kHz results
// - Select pins choose the active channel
// - Select change sensed on falling clock edge
// - Select change restarts conversion from start
// - First ready after change is new channel
// - Five conversion cycles settle before ready
// - Multiplexed rate near 3.5kHz from settling
// - Modulator clock is system clock over six
// - One result per 64 modulator cycles
package amcc_pkg;
  localparam int          MOD_DIVIDE     = 6;
  localparam int          OVERSAMPLE     = 64;
  localparam int          SETTLE_CYCLES  = 5;
  localparam int          RESULT_WIDTH   = 24;
  localparam int          FIFO_DEPTH     = 8;
  localparam logic [1:0]  CHANNEL_RESET  = 2'h0;
  localparam logic        READY_IDLE     = 1'b1;

  typedef enum logic [2:0] {
    AMCC_RESTART = 3'b001,
    AMCC_SETTLE  = 3'b010,
    AMCC_RUN     = 3'b100
  } amcc_state_type;
endpackage

/* logic/amcc_control.sv */
/*
  Channel mux and conversion sequencing of a delta-sigma converter.
  Assumes the filter datapath supplies a sample each modulator tick
  and the serial shifter reports the start of each readout.
*/
`timescale 1ns/1ps
module amcc_control
  import amcc_pkg::*;
#(
  parameter int DIVIDE = MOD_DIVIDE,
  parameter int OSR    = OVERSAMPLE,
  parameter int SETTLE = SETTLE_CYCLES,
  parameter int WIDTH  = RESULT_WIDTH,
  parameter int DEPTH  = FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Channel select pins
  input  wire logic             channel_select_high,
  input  wire logic             channel_select_low,
  // Filter datapath
  input  wire logic [WIDTH-1:0] filter_result,
  output logic                  modulator_tick,
  output logic                  conversion_restart,
  output logic [1:0]            active_channel,
  // Serial readout
  input  wire logic             shift_start,
  output logic [WIDTH-1:0]      output_data,
  output logic [1:0]            output_channel,
  output logic                  data_out_ready_pin,
  output logic                  result_ready_flag
);
  localparam int DW = $clog2(DIVIDE);
  localparam int OW = $clog2(OSR);
  localparam int SW = $clog2(SETTLE + 1);

  amcc_state_type   state;
  amcc_state_type   next_state;
  logic [DW-1:0]    div_count;
  logic [DW-1:0]    next_div_count;
  logic [OW-1:0]    osr_count;
  logic [OW-1:0]    next_osr_count;
  logic [SW-1:0]    settle_count;
  logic [SW-1:0]    next_settle_count;
  logic [1:0]       select_fall;
  logic [1:0]       select_seen;
  logic [1:0]       next_select_seen;
  logic             next_modulator_tick;
  logic             next_restart;
  logic             result_done;
  logic             fifo_in_ready;
  logic             fifo_out_valid;
  logic [WIDTH+1:0] fifo_out_data;
  logic             fifo_pop;
  logic [WIDTH-1:0] next_output_data;
  logic [1:0]       next_output_channel;
  logic             next_ready_flag;
  logic             busy;
  logic             next_busy;

  // Select pins sampled on the falling edge
  always_ff @(negedge clk) begin
    if (rst) begin
      select_fall <= CHANNEL_RESET;
    end else begin
      select_fall <= {channel_select_high, channel_select_low};
    end
  end

  // Channel change detect and restart
  always_comb begin
    next_select_seen = select_fall;
    next_restart     = (select_fall != select_seen);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      select_seen        <= CHANNEL_RESET;
      conversion_restart <= 1'b1;
      active_channel     <= CHANNEL_RESET;
    end else begin
      select_seen        <= next_select_seen;
      conversion_restart <= next_restart;
      active_channel     <= select_seen;
    end
  end

  // Modulator divider and decimation counter
  assign result_done = modulator_tick && (osr_count == OW'(OSR - 1));

  always_comb begin
    next_div_count      = div_count;
    next_osr_count      = osr_count;
    next_modulator_tick = 1'b0;
    if (conversion_restart) begin
      next_div_count = '0;
      next_osr_count = '0;
    end else begin
      if (div_count == DW'(DIVIDE - 1)) begin
        next_div_count      = '0;
        next_modulator_tick = 1'b1;
      end else begin
        next_div_count = div_count + 1'b1;
      end
      if (modulator_tick) begin
        next_osr_count = (osr_count == OW'(OSR - 1)) ? '0
                                                     : osr_count + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      div_count      <= '0;
      osr_count      <= '0;
      modulator_tick <= 1'b0;
    end else begin
      div_count      <= next_div_count;
      osr_count      <= next_osr_count;
      modulator_tick <= next_modulator_tick;
    end
  end

  // Settling sequence
  always_comb begin
    next_state        = state;
    next_settle_count = settle_count;
    unique case (state)
      AMCC_RESTART: begin
        next_settle_count = '0;
        next_state        = AMCC_SETTLE;
      end
      AMCC_SETTLE: begin
        if (result_done) begin
          next_settle_count = settle_count + 1'b1;
          if (settle_count == SW'(SETTLE - 1)) begin
            next_state = AMCC_RUN;
          end
        end
      end
      AMCC_RUN: begin
        next_state = AMCC_RUN;
      end
    endcase
    if (conversion_restart) begin
      next_state = AMCC_RESTART;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state        <= AMCC_RESTART;
      settle_count <= '0;
    end else begin
      state        <= next_state;
      settle_count <= next_settle_count;
    end
  end

  // Result queue, flushed on restart so stale channels never surface
  amcc_fifo #(
    .WIDTH (WIDTH + 2),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .flush     (conversion_restart),
    .in_valid  (result_done && (state == AMCC_RUN) && !conversion_restart),
    .in_ready  (fifo_in_ready),
    .in_data   ({active_channel, filter_result}),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data)
  );

  // Output register and ready pin
  assign fifo_pop = fifo_out_valid && !busy && !conversion_restart;

  always_comb begin
    next_output_data    = output_data;
    next_output_channel = output_channel;
    next_ready_flag     = result_ready_flag;
    next_busy           = busy;
    if (shift_start) begin
      next_ready_flag = 1'b0;
      next_busy       = 1'b0;
    end
    if (fifo_pop) begin
      next_output_data    = fifo_out_data[WIDTH-1:0];
      next_output_channel = fifo_out_data[WIDTH+1:WIDTH];
      next_ready_flag     = 1'b1;
      next_busy           = 1'b1;
    end
    if (conversion_restart) begin
      next_ready_flag = 1'b0;
      next_busy       = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      output_data        <= '0;
      output_channel     <= CHANNEL_RESET;
      result_ready_flag  <= 1'b0;
      data_out_ready_pin <= READY_IDLE;
      busy               <= 1'b0;
    end else begin
      output_data        <= next_output_data;
      output_channel     <= next_output_channel;
      result_ready_flag  <= next_ready_flag;
      data_out_ready_pin <= !next_ready_flag;
      busy               <= next_busy;
    end
  end
endmodule

/* logic/amcc_fifo.sv */
/*
  Small flip-flop FIFO with valid/ready on both sides.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module amcc_fifo #(
  parameter int WIDTH = 26,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             flush,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH];
  logic [WIDTH-1:0] next_store [DEPTH];
  logic [AW-1:0]    rd_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW:0]      count;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = store[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_store  = store;
    next_rd_ptr = rd_ptr;
    next_wr_ptr = wr_ptr;
    next_count  = count;
    if (push) begin
      next_store[wr_ptr] = in_data;
      next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
    if (flush) begin
      next_rd_ptr = '0;
      next_wr_ptr = '0;
      next_count  = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_ptr <= '0;
      wr_ptr <= '0;
      count  <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        store[i] <= '0;
      end
    end else begin
      rd_ptr <= next_rd_ptr;
      wr_ptr <= next_wr_ptr;
      count  <= next_count;
      store  <= next_store;
    end
  end
endmodule

/* tb/amcc_control_assertions.sv */
/* Port checks for the conversion control.
   Assumes bind to amcc_control with its count parameters. */
`timescale 1ns/1ps
module amcc_control_assertions #(
  parameter int DIVIDE = 6,
  parameter int OSR    = 64,
  parameter int SETTLE = 5,
  parameter int WIDTH  = 24
) (
  // Clock, reset, select
  input wire logic             clk,
  input wire logic             rst,
  input wire logic             channel_select_high,
  input wire logic             channel_select_low,
  // Filter side
  input wire logic [WIDTH-1:0] filter_result,
  input wire logic             modulator_tick,
  input wire logic             conversion_restart,
  input wire logic [1:0]       active_channel,
  // Readout side
  input wire logic             shift_start,
  input wire logic [WIDTH-1:0] output_data,
  input wire logic [1:0]       output_channel,
  input wire logic             data_out_ready_pin,
  input wire logic             result_ready_flag
);
  localparam int SETTLE_MIN = (SETTLE + 1) * DIVIDE * OSR - DIVIDE;
  logic [1:0] sel;
  int         gap, next_gap, since, next_since;
  logic       seen, next_seen;
  assign sel = {channel_select_high, channel_select_low};
  always_comb begin
    next_gap   = modulator_tick ? 0 : gap + 1;
    next_seen  = (seen | modulator_tick) & !conversion_restart;
    next_since = conversion_restart ? 0 : since + 1;
  end
  always_ff @(posedge clk) begin
    gap   <= rst ? 0 : next_gap;
    seen  <= rst ? 1'b0 : next_seen;
    since <= rst ? 0 : next_since;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_sel_moved;
    sel != $past(sel);
  endsequence
  sequence s_restart_soon;
    ##[1:2] conversion_restart;
  endsequence
  AST_FLAG_INVERSE: assert property (
    result_ready_flag == !data_out_ready_pin) else $error("flag mismatch");
  AST_TICK_PERIOD: assert property (
    modulator_tick && seen |-> gap == DIVIDE - 1) else $error("tick gap");
  AST_SELECT_FOLLOW: assert property (
    $stable(sel) [*3] |-> active_channel == sel) else $error("channel");
  AST_CHANGE_RESTART: assert property (
    s_sel_moved |-> s_restart_soon) else $error("no restart");
  AST_SETTLE_WAIT: assert property (
    $fell(data_out_ready_pin) |-> since >= SETTLE_MIN) else $error("early");
  AST_READY_HOLD: assert property (
    !data_out_ready_pin && !shift_start && !conversion_restart |=>
    !data_out_ready_pin && $stable(output_data)) else $error("hold");
  AST_READY_RELEASE: assert property (
    shift_start && !data_out_ready_pin |=> data_out_ready_pin)
    else $error("no release");
  AST_FIRST_CHANNEL: assert property (
    $fell(data_out_ready_pin) |-> output_channel == active_channel)
    else $error("stale channel");
endmodule
bind amcc_control amcc_control_assertions #(.DIVIDE(DIVIDE), .OSR(OSR),
  .SETTLE(SETTLE), .WIDTH(WIDTH)) u_chk (.clk(clk), .rst(rst),
  .channel_select_high(channel_select_high),
  .channel_select_low(channel_select_low), .filter_result(filter_result),
  .modulator_tick(modulator_tick), .conversion_restart(conversion_restart),
  .active_channel(active_channel), .shift_start(shift_start),
  .output_data(output_data), .output_channel(output_channel),
  .data_out_ready_pin(data_out_ready_pin),
  .result_ready_flag(result_ready_flag));

/* tb/amcc_host_model.sv */
/* Host model: pulses shift_start to read each fresh result.
   Assumes the bench may stall it; acts on the falling edge. */
`timescale 1ns/1ps
module amcc_host_model #(
  parameter int WIDTH = 24
) (
  // Clock, reset, stall
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             stall,
  // Device readout
  input  wire logic             data_out_ready_pin,
  input  wire logic [WIDTH-1:0] output_data,
  input  wire logic [1:0]       output_channel,
  output logic                  shift_start,
  // Captured word
  output logic                  got_valid,
  output logic [WIDTH+1:0]      got_word
);
  initial shift_start = 1'b0;
  initial got_valid = 1'b0;
  // Never reads on the cycle after a read
  always @(negedge clk) begin
    shift_start <= 1'b0;
    got_valid   <= 1'b0;
    if (!rst && !stall && !data_out_ready_pin &&
        !shift_start) begin
      shift_start <= 1'b1;
      got_valid   <= 1'b1;
      got_word    <= {output_channel, output_data};
    end
  end
endmodule

/* tb/test_adc_channel_mux_conversion_control.sv */
/* Self-checking bench for the conversion control.
   Assumes shrunk counts and the host model reading results. */
`timescale 1ns/1ps
module test_adc_channel_mux_conversion_control;
  import amcc_pkg::*;
  logic        clk, rst, channel_select_high, channel_select_low, stall;
  logic        shift_start, data_out_ready_pin, result_ready_flag, got_valid;
  logic [23:0] filter_result, output_data;
  logic [1:0]  output_channel;
  logic [25:0] got_word, exp_word, exp_q[$];
  int          n_errors, checks, n_got;
  amcc_control #(.DIVIDE(2), .OSR(4), .SETTLE(2)) dut (.clk(clk),
    .rst(rst), .channel_select_high(channel_select_high),
    .channel_select_low(channel_select_low), .filter_result(filter_result),
    .modulator_tick(), .conversion_restart(), .active_channel(),
    .shift_start(shift_start), .output_data(output_data),
    .output_channel(output_channel), .data_out_ready_pin(data_out_ready_pin),
    .result_ready_flag(result_ready_flag));
  amcc_host_model host (.clk(clk), .rst(rst), .stall(stall),
    .data_out_ready_pin(data_out_ready_pin), .output_data(output_data),
    .output_channel(output_channel), .shift_start(shift_start),
    .got_valid(got_valid), .got_word(got_word));
  task automatic check(input logic [25:0] seen, input logic [25:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks=%0d errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Change channel, wait, then read n results of it
  task automatic conv(input logic [1:0] ch, input int n, input int hold);
    @(negedge clk);
    {channel_select_high, channel_select_low} <= ch;
    filter_result <= 24'($urandom);
    repeat (hold) @(negedge clk);
    if (hold > 30) begin
      check({24'h0, data_out_ready_pin, result_ready_flag}, 26'h1);
    end
    repeat (n) exp_q.push_back({ch, filter_result});
    n_got = 0;
    if (n > 0) stall <= 1'b0;
    for (int i = 0; i < 2000 && n_got < n; i++) @(negedge clk);
    stall <= 1'b1;
    check(26'(n_got), 26'(n));
    $display("test ch=%0d reads=%0d done", ch, n);
  endtask
  always @(posedge clk) begin
    if (got_valid) begin
      n_got++;
      exp_word = exp_q.size() ? exp_q.pop_front() : ~got_word;
      check(got_word, exp_word);
    end
  end
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #(20000 * 8);
    n_errors++;
    complete_run();
  end
  initial begin
    rst = 1'b1;
    stall = 1'b1;
    {channel_select_high, channel_select_low} = CHANNEL_RESET;
    filter_result = 24'h0;
    void'($urandom(32'hd317));
    repeat (6) @(negedge clk);
    rst <= 1'b0;
    // Host stays stalled until the restart has cleared any stale result
    for (int c = 1; c < 5; c++) conv(2'(c), 2, 4);
    conv(2'h1, 0, 40);
    conv(2'h2, 2, 4);
    conv(2'h3, 8, 120);
    conv(2'h0, 2, 4);
    complete_run();
  end
endmodule
